// file: rtl/sslc_pkg.sv
`default_nettype none
package sslc_pkg;
  localparam int SSLC_CNT_W = 4;
  localparam int SSLC_CAL_W = 8;
  localparam int SSLC_TRAIN_W = 8;
  localparam int SSLC_USER_W = 32;
  localparam logic [1:0] SSLC_FRAME_WORD = 2'h3;
  localparam logic [1:0] SSLC_SATISFIED = 2'h2;
  localparam logic [1:0] SSLC_DIP_INV = 2'h3;
  localparam logic [2:0] SSLC_FRAME_RUN = 3'h4;
  localparam logic [15:0] SSLC_IDLE_DATA = 16'h000f;
  localparam logic [15:0] SSLC_TRAIN_CTL = 16'h0fff;
  localparam logic [15:0] SSLC_TRAIN_DAT = 16'hf000;

  typedef struct packed {
    logic ctl;
    logic [15:0] data;
  } sslc_word_s;

  localparam sslc_word_s SSLC_IDLE = '{ctl: 1'b1, data: SSLC_IDLE_DATA};
  localparam sslc_word_s SSLC_TRAIN_A = '{ctl: 1'b1, data: SSLC_TRAIN_CTL};
  localparam sslc_word_s SSLC_TRAIN_B = '{ctl: 1'b0, data: SSLC_TRAIN_DAT};

  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_TRAIN = 3'b010,
    TX_RUN = 3'b100
  } sslc_tx_e;

  typedef enum logic [3:0] {
    RX_HUNT = 4'b0001,
    RX_CAL = 4'b0010,
    RX_DIP = 4'b0100,
    RX_FRAME = 4'b1000
  } sslc_rx_e;

  // levels and toggle passed from the status domain to the main domain
  typedef struct packed {
    logic en;
    logic oof;
    logic hungry;
    logic dip;
  } sslc_xing_s;

  typedef struct packed {
    sslc_tx_e phase;
    logic [SSLC_TRAIN_W-1:0] train_cnt;
    logic hold_full;
    logic [SSLC_USER_W-1:0] hold_data;
    logic dip_d;
    sslc_word_s rise;
    sslc_word_s fall;
    logic oof_out;
    logic perr;
  } sslc_tx_s;

  typedef struct packed {
    sslc_rx_e phase;
    logic [2:0] hunt_cnt;
    logic [SSLC_CAL_W-1:0] cal_cnt;
    logic [1:0] acc;
    logic [SSLC_CNT_W-1:0] err_cnt;
    logic [SSLC_CNT_W-1:0] match_cnt;
    sslc_xing_s x;
  } sslc_rx_s;

  localparam sslc_tx_s SSLC_TX_RST = '{phase: TX_IDLE, train_cnt: '0,
    hold_full: 1'b0, hold_data: '0, dip_d: 1'b0, rise: SSLC_IDLE,
    fall: SSLC_IDLE, oof_out: 1'b1, perr: 1'b0};

  localparam sslc_rx_s SSLC_RX_RST = '{phase: RX_HUNT, hunt_cnt: '0,
    cal_cnt: '0, acc: '0, err_cnt: '0, match_cnt: '0,
    x: '{en: 1'b0, oof: 1'b1, hungry: 1'b0, dip: 1'b0}};

  // expected parity word from the xor of all calendar entries
  function automatic logic [1:0] sslc_dip2(input logic [1:0] acc);
    return acc ^ SSLC_DIP_INV;
  endfunction
endpackage
`default_nettype wire

// file: rtl/sslc_sync.sv
`default_nettype none
module sslc_sync import sslc_pkg::*; #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] hold;
  } sslc_sync_s;

  sslc_sync_s s_ff;
  sslc_sync_s nxt_s;

  always_comb begin
    nxt_s.meta = d;
    nxt_s.hold = s_ff.meta;
  end

  always_ff @(posedge clock) begin
    s_ff <= nxt_s;
  end

  assign q = s_ff.hold;
endmodule
`default_nettype wire

// file: rtl/sslc_status_rx.sv
`default_nettype none
module sslc_status_rx import sslc_pkg::*; #(
  parameter int CAL_LEN = 8
) (
  input wire logic tx_status_domain_clock,
  input wire logic reset_n,
  input wire logic [1:0] tx_fifo_status,
  input wire logic tx_core_enable,
  input wire logic [SSLC_CNT_W-1:0] sync_loss_error_count,
  input wire logic [SSLC_CNT_W-1:0] sync_gain_match_count,
  output sslc_xing_s x_out
);
  localparam logic [SSLC_CAL_W-1:0] CAL_LAST = SSLC_CAL_W'(CAL_LEN - 1);

  logic rst_ok;
  logic dip_ok;
  logic take;
  sslc_rx_s s_ff;
  sslc_rx_s nxt_s;

  sslc_sync #(.W(1)) u_rst (
    .clock(tx_status_domain_clock),
    .d(reset_n),
    .q(rst_ok)
  );

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_s = s_ff;
    take = 1'b0;
    dip_ok = tx_fifo_status == sslc_dip2(s_ff.acc);
    nxt_s.x.en = tx_core_enable;
    if (!rst_ok) begin
      nxt_s = SSLC_RX_RST;
    end else if (!tx_core_enable) begin
      nxt_s = SSLC_RX_RST;
      nxt_s.x.dip = s_ff.x.dip;
    end else begin
      case (s_ff.phase)
        RX_HUNT: begin
          if (tx_fifo_status == SSLC_FRAME_WORD) begin
            if (s_ff.hunt_cnt != 3'h7) begin
              nxt_s.hunt_cnt = s_ff.hunt_cnt + 3'h1;
            end
          end else begin
            take = s_ff.hunt_cnt >= SSLC_FRAME_RUN;
            nxt_s.hunt_cnt = 3'h0;
          end
        end
        RX_FRAME: begin
          if (tx_fifo_status == SSLC_FRAME_WORD) begin
            nxt_s.phase = RX_CAL;
          end else begin
            nxt_s.x.oof = 1'b1;
            nxt_s.match_cnt = '0;
            nxt_s.phase = RX_HUNT;
          end
        end
        RX_CAL: begin
          take = 1'b1;
        end
        RX_DIP: begin
          nxt_s.cal_cnt = '0;
          nxt_s.acc = 2'h0;
          nxt_s.phase = RX_FRAME;
          if (dip_ok) begin
            nxt_s.err_cnt = '0;
            if (s_ff.match_cnt != '1) begin
              nxt_s.match_cnt = s_ff.match_cnt + 1'b1;
            end
            if ((5'(s_ff.match_cnt) + 5'h1) >= 5'(sync_gain_match_count)) begin
              nxt_s.x.oof = 1'b0;
            end
          end else begin
            nxt_s.match_cnt = '0;
            nxt_s.x.dip = ~s_ff.x.dip;
            if (s_ff.err_cnt != '1) begin
              nxt_s.err_cnt = s_ff.err_cnt + 1'b1;
            end
            if ((5'(s_ff.err_cnt) + 5'h1) >= 5'(sync_loss_error_count)) begin
              nxt_s.x.oof = 1'b1;
              nxt_s.phase = RX_HUNT;
            end
          end
        end
        default: nxt_s = SSLC_RX_RST;
      endcase
      if (take) begin
        nxt_s.acc = s_ff.acc ^ tx_fifo_status;
        if (s_ff.cal_cnt == '0) begin
          nxt_s.x.hungry = tx_fifo_status != SSLC_SATISFIED;
        end
        nxt_s.cal_cnt = s_ff.cal_cnt + 1'b1;
        nxt_s.phase = (s_ff.cal_cnt == CAL_LAST) ? RX_DIP : RX_CAL;
      end
    end
  end

  always_ff @(posedge tx_status_domain_clock) begin
    s_ff <= nxt_s;
  end

  assign x_out = s_ff.x;

  //////////////////////////////////////////////////////////////////////////
  property p_disabled_quiet;
    @(posedge tx_status_domain_clock) disable iff (!rst_ok)
    !tx_core_enable |=> s_ff.x.oof && $stable(s_ff.x.dip) && !s_ff.x.en;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("status logic active while disabled");

  property p_loss_on_errors;
    @(posedge tx_status_domain_clock) disable iff (!rst_ok)
    (s_ff.phase == RX_DIP && tx_core_enable && !dip_ok &&
     (5'(s_ff.err_cnt) + 5'h1) >= 5'(sync_loss_error_count))
    |=> s_ff.x.oof && s_ff.phase == RX_HUNT;
  endproperty
  a_loss_on_errors: assert property (p_loss_on_errors)
    else $error("sync not lost after parity errors");

  property p_frame_word_bad;
    @(posedge tx_status_domain_clock) disable iff (!rst_ok)
    (s_ff.phase == RX_FRAME && tx_core_enable &&
     tx_fifo_status != SSLC_FRAME_WORD) |=> s_ff.x.oof ##1 s_ff.x.oof;
  endproperty
  a_frame_word_bad: assert property (p_frame_word_bad)
    else $error("bad framing word did not drop frame");
endmodule
`default_nettype wire

// file: rtl/sslc_top.sv
`default_nettype none
module sslc_top import sslc_pkg::*; #(
  parameter int CAL_LEN = 8,
  parameter int TRAIN_REPS = 10
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic tx_status_domain_clock,
  input wire logic [1:0] tx_fifo_status,
  input wire logic tx_core_enable,
  input wire logic [SSLC_CNT_W-1:0] sync_loss_error_count,
  input wire logic [SSLC_CNT_W-1:0] sync_gain_match_count,
  input wire logic tx_fifo_clear_low,
  input wire logic wr_valid,
  input wire logic [SSLC_USER_W-1:0] wr_data,
  output logic wr_ready,
  output logic tx_data_clock,
  output logic [15:0] tx_data,
  output logic tx_ctl,
  output sslc_word_s tx_word_rise,
  output sslc_word_s tx_word_fall,
  output logic tx_out_of_frame,
  output logic status_parity_error,
  output logic write_pattern_error
);
  localparam logic [SSLC_TRAIN_W-1:0] TRAIN_HALF =
    SSLC_TRAIN_W'(TRAIN_REPS / 2);
  localparam logic [SSLC_TRAIN_W-1:0] TRAIN_LAST =
    SSLC_TRAIN_W'(TRAIN_REPS - 1);

  logic rst_ok;
  logic link_up;
  logic send;
  sslc_xing_s x_raw;
  sslc_xing_s x_s;
  sslc_tx_s s_ff;
  sslc_tx_s nxt_s;

  //////////////////////////////////////////////////////////////////////////
  // reset release and crossings into the main domain
  sslc_sync #(.W(1)) u_rst (
    .clock(clock),
    .d(reset_n),
    .q(rst_ok)
  );

  sslc_status_rx #(.CAL_LEN(CAL_LEN)) u_status (
    .tx_status_domain_clock(tx_status_domain_clock),
    .reset_n(reset_n),
    .tx_fifo_status(tx_fifo_status),
    .tx_core_enable(tx_core_enable),
    .sync_loss_error_count(sync_loss_error_count),
    .sync_gain_match_count(sync_gain_match_count),
    .x_out(x_raw)
  );

  sslc_sync #(.W($bits(sslc_xing_s))) u_xing (
    .clock(clock),
    .d(x_raw),
    .q(x_s)
  );

  //////////////////////////////////////////////////////////////////////////
  // transmit sequencing
  assign link_up = x_s.en & ~x_s.oof;
  assign send = (s_ff.phase == TX_RUN) & link_up & s_ff.hold_full &
                x_s.hungry;
  assign wr_ready = rst_ok & tx_fifo_clear_low &
                    (~s_ff.hold_full | send);

  always_comb begin
    nxt_s = s_ff;
    nxt_s.dip_d = x_s.dip;
    nxt_s.perr = (x_s.dip ^ s_ff.dip_d) & x_s.en;
    nxt_s.oof_out = x_s.oof | ~x_s.en;
    case (s_ff.phase)
      TX_IDLE: begin
        nxt_s.rise = SSLC_IDLE;
        nxt_s.fall = SSLC_IDLE;
        nxt_s.train_cnt = '0;
        nxt_s.phase = TX_TRAIN;
      end
      TX_TRAIN: begin
        // a full training pattern is always finished before data
        if (s_ff.train_cnt < TRAIN_HALF) begin
          nxt_s.rise = SSLC_TRAIN_A;
          nxt_s.fall = SSLC_TRAIN_A;
        end else begin
          nxt_s.rise = SSLC_TRAIN_B;
          nxt_s.fall = SSLC_TRAIN_B;
        end
        if (s_ff.train_cnt == TRAIN_LAST) begin
          nxt_s.train_cnt = '0;
          if (link_up) begin
            nxt_s.phase = TX_RUN;
          end
        end else begin
          nxt_s.train_cnt = s_ff.train_cnt + 1'b1;
        end
      end
      TX_RUN: begin
        nxt_s.rise = SSLC_IDLE;
        nxt_s.fall = SSLC_IDLE;
        if (!link_up) begin
          nxt_s.train_cnt = '0;
          nxt_s.phase = TX_TRAIN;
        end else if (send) begin
          nxt_s.rise = '{ctl: 1'b0, data: s_ff.hold_data[31:16]};
          nxt_s.fall = '{ctl: 1'b0, data: s_ff.hold_data[15:0]};
        end
      end
      default: nxt_s = SSLC_TX_RST;
    endcase
    if (send) begin
      nxt_s.hold_full = 1'b0;
    end
    if (wr_valid && wr_ready) begin
      nxt_s.hold_full = 1'b1;
      nxt_s.hold_data = wr_data;
    end
    if (!tx_fifo_clear_low) begin
      nxt_s.hold_full = 1'b0;
    end
    if (!rst_ok) begin
      nxt_s = SSLC_TX_RST;
    end
  end

  always_ff @(posedge clock) begin
    s_ff <= nxt_s;
  end

  //////////////////////////////////////////////////////////////////////////
  // double data rate launch with forwarded clock
  assign tx_data_clock = clock;
  assign tx_data = clock ? s_ff.rise.data : s_ff.fall.data;
  assign tx_ctl = clock ? s_ff.rise.ctl : s_ff.fall.ctl;
  assign tx_word_rise = s_ff.rise;
  assign tx_word_fall = s_ff.fall;
  assign tx_out_of_frame = s_ff.oof_out;
  assign status_parity_error = s_ff.perr;
  // pattern checks live with the fifo write side, not here
  assign write_pattern_error = 1'b0;

  //////////////////////////////////////////////////////////////////////////
  default clocking cb_main @(posedge clock);
  endclocking

  property p_idle_in_reset;
    !rst_ok |=> s_ff.rise == SSLC_IDLE && s_ff.fall == SSLC_IDLE &&
                tx_out_of_frame;
  endproperty
  a_idle_in_reset: assert property (p_idle_in_reset)
    else $error("non idle word during reset");

  property p_train_after_release;
    disable iff (!rst_ok)
    $rose(rst_ok) |=> s_ff.phase == TX_TRAIN ##1 s_ff.rise == SSLC_TRAIN_A;
  endproperty
  a_train_after_release: assert property (p_train_after_release)
    else $error("no training after reset release");

  property p_train_disabled;
    disable iff (!rst_ok)
    (!x_s.en && s_ff.phase == TX_TRAIN) |=>
      (s_ff.rise == SSLC_TRAIN_A || s_ff.rise == SSLC_TRAIN_B) &&
      s_ff.phase == TX_TRAIN;
  endproperty
  a_train_disabled: assert property (p_train_disabled)
    else $error("training not held while disabled");

  property p_payload_ctl_low;
    disable iff (!rst_ok)
    send |=> !s_ff.rise.ctl && !s_ff.fall.ctl &&
             s_ff.rise.data == $past(s_ff.hold_data[31:16]) &&
             s_ff.fall.data == $past(s_ff.hold_data[15:0]);
  endproperty
  a_payload_ctl_low: assert property (p_payload_ctl_low)
    else $error("payload word not marked as data");

  property p_flow_gated;
    disable iff (!rst_ok)
    (!s_ff.rise.ctl && $past(s_ff.phase) == TX_RUN) |->
      $past(x_s.hungry) && $past(link_up);
  endproperty
  a_flow_gated: assert property (p_flow_gated)
    else $error("payload sent against flow control");

  property p_clear_then_idle;
    disable iff (!rst_ok)
    !tx_fifo_clear_low |=> !s_ff.hold_full ##1
      (s_ff.rise.ctl || $past(s_ff.phase) != TX_RUN);
  endproperty
  a_clear_then_idle: assert property (p_clear_then_idle)
    else $error("data sent right after fifo clear");

  property p_clear_keeps_frame;
    disable iff (!rst_ok)
    (!tx_fifo_clear_low && s_ff.phase == TX_RUN && link_up) |=>
      s_ff.phase == TX_RUN;
  endproperty
  a_clear_keeps_frame: assert property (p_clear_keeps_frame)
    else $error("fifo clear left run state");

  property p_perr_single;
    disable iff (!rst_ok)
    status_parity_error |=> !status_parity_error;
  endproperty
  a_perr_single: assert property (p_perr_single)
    else $error("parity error pulse longer than one cycle");

  property p_oof_follows;
    disable iff (!rst_ok)
    (x_s.oof || !x_s.en) |=> tx_out_of_frame;
  endproperty
  a_oof_follows: assert property (p_oof_follows)
    else $error("out of frame not reported");

  property p_ready_refused;
    (!rst_ok || !tx_fifo_clear_low) |-> !wr_ready;
  endproperty
  a_ready_refused: assert property (p_ready_refused)
    else $error("write accepted while cleared or in reset");

  property p_restart_state;
    !rst_ok |=> s_ff.phase == TX_IDLE && !s_ff.hold_full &&
                !status_parity_error;
  endproperty
  a_restart_state: assert property (p_restart_state)
    else $error("core not restarted by reset");

  property p_write_lands;
    disable iff (!rst_ok)
    (wr_valid && wr_ready) |=>
      s_ff.hold_full && s_ff.hold_data == $past(wr_data);
  endproperty
  a_write_lands: assert property (p_write_lands)
    else $error("accepted write not held");

  property p_ctl_words;
    disable iff (!rst_ok)
    s_ff.rise.ctl |-> s_ff.rise == SSLC_IDLE || s_ff.rise == SSLC_TRAIN_A;
  endproperty
  a_ctl_words: assert property (p_ctl_words)
    else $error("control flag on a non control word");

  property p_rise_half;
    @(negedge clock) disable iff (!rst_ok)
    tx_data == s_ff.rise.data && tx_ctl == s_ff.rise.ctl;
  endproperty
  a_rise_half: assert property (p_rise_half)
    else $error("bus does not show rising half word");

  property p_fall_half;
    disable iff (!rst_ok)
    tx_data == s_ff.fall.data && tx_ctl == s_ff.fall.ctl;
  endproperty
  a_fall_half: assert property (p_fall_half)
    else $error("bus does not show falling half word");

  property p_train_halves;
    disable iff (!rst_ok)
    s_ff.phase == TX_TRAIN |=> s_ff.rise == s_ff.fall;
  endproperty
  a_train_halves: assert property (p_train_halves)
    else $error("training halves differ");

  property p_run_needs_link;
    disable iff (!rst_ok)
    s_ff.phase == TX_RUN |-> $past(link_up);
  endproperty
  a_run_needs_link: assert property (p_run_needs_link)
    else $error("run state without a live link");

  property p_loss_retrains;
    disable iff (!rst_ok)
    (s_ff.phase == TX_RUN && !link_up) |=>
      s_ff.phase == TX_TRAIN && s_ff.rise == SSLC_IDLE;
  endproperty
  a_loss_retrains: assert property (p_loss_retrains)
    else $error("loss of frame did not restart training");

  property p_gain_needs_enable;
    disable iff (!rst_ok)
    $fell(tx_out_of_frame) |-> $past(x_s.en) && !$past(x_s.oof);
  endproperty
  a_gain_needs_enable: assert property (p_gain_needs_enable)
    else $error("in frame reported without enable");

  property p_perr_on_toggle;
    disable iff (!rst_ok)
    ($changed(x_s.dip) && x_s.en) |=> status_parity_error;
  endproperty
  a_perr_on_toggle: assert property (p_perr_on_toggle)
    else $error("parity error not reported");

  property p_pattern_quiet;
    disable iff (!rst_ok)
    !x_s.en |=> !status_parity_error && !write_pattern_error;
  endproperty
  a_pattern_quiet: assert property (p_pattern_quiet)
    else $error("error output raised while disabled");
endmodule
`default_nettype wire

// file: bench/sslc_sink_model.sv
`default_nettype none
module sslc_sink_model import sslc_pkg::*; #(
  parameter int CAL_LEN = 8
) (
  input wire logic bad_dip,
  input wire logic break_frame,
  input wire logic hungry,
  output logic stat_clock,
  output logic [1:0] status
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] acc;
  logic [1:0] ent;
  ////////////////////////////////////////////////////////////////////////
  // status clock runs free; words change on its falling edge
  initial begin
    stat_clock = 1'b0;
    forever #6 stat_clock = ~stat_clock;
  end
  task automatic send(input logic [1:0] w);
    @(negedge stat_clock);
    status = w;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    status = SSLC_FRAME_WORD;
    repeat (4) send(SSLC_FRAME_WORD);
    forever begin
      acc = 2'h0;
      for (int k = 0; k < CAL_LEN; k++) begin
        ent = (k == 0) ? (hungry ? 2'h1 : SSLC_SATISFIED) : 2'(k);
        acc = acc ^ ent;
        send(ent);
      end
      // parity word, optionally corrupted
      send(acc ^ SSLC_DIP_INV ^ {1'b0, bad_dip});
      if (break_frame) begin
        send(2'h0);
        repeat (4) send(SSLC_FRAME_WORD);
      end else begin
        send(SSLC_FRAME_WORD);
      end
    end
  end
endmodule
`default_nettype wire

// file: bench/testbench.sv
`default_nettype none
module testbench import sslc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic en = 1'b0;
  logic clr_low = 1'b1;
  logic wr_valid = 1'b0;
  logic [31:0] wr_data = 32'h0;
  logic bad_dip = 1'b0;
  logic brk = 1'b0;
  logic hungry = 1'b0;
  logic [3:0] err_lim = 4'h2;
  logic [3:0] match_lim = 4'h3;
  logic stat_clk;
  logic [1:0] stat;
  logic wr_ready;
  logic dclk;
  logic [15:0] tx_data;
  logic tx_ctl;
  sslc_word_s rise;
  sslc_word_s fall;
  logic oof;
  logic perr;
  logic pat_err;
  logic perr_d = 1'b0;
  int fail_count = 0;
  int num_checks = 0;
  int perr_seen = 0;
  always #25 clock = ~clock;
  // calendar is static here, nothing to program after release
  sslc_top #(.CAL_LEN(8), .TRAIN_REPS(10)) u_sslc_top (
    .clock(clock), .reset_n(reset_n), .tx_status_domain_clock(stat_clk),
    .tx_fifo_status(stat), .tx_core_enable(en),
    .sync_loss_error_count(err_lim), .sync_gain_match_count(match_lim),
    .tx_fifo_clear_low(clr_low), .wr_valid(wr_valid), .wr_data(wr_data),
    .wr_ready(wr_ready), .tx_data_clock(dclk), .tx_data(tx_data),
    .tx_ctl(tx_ctl), .tx_word_rise(rise), .tx_word_fall(fall),
    .tx_out_of_frame(oof), .status_parity_error(perr),
    .write_pattern_error(pat_err));
  sslc_sink_model #(.CAL_LEN(8)) u_sslc_sink_model (
    .bad_dip(bad_dip), .break_frame(brk), .hungry(hungry),
    .stat_clock(stat_clk), .status(stat));
  ////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check_bit(input string n, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic check_word(input string n, input sslc_word_s e,
                            input sslc_word_s g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic check_num(input string n, input int e, input int g);
    num_checks++;
    if (g != e) begin
      fail_count++;
      $display("[FAIL] %s expected %0d seen %0d", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic wait_rise(input sslc_word_s e, input int lim);
    for (int i = 0; i < lim && rise !== e; i++) @(negedge clock);
  endtask
  task automatic wait_oof(input logic e, input int lim);
    for (int i = 0; i < lim && oof !== e; i++) @(negedge clock);
    check_bit("out of frame", e, oof);
  endtask
  task automatic write(input logic [31:0] d);
    wr_valid = 1'b1;
    wr_data = d;
    for (int i = 0; i < 50 && wr_ready !== 1'b1; i++) @(negedge clock);
    check_bit("write taken", 1'b1, wr_ready);
    @(negedge clock);
    wr_valid = 1'b0;
  endtask
  // parity pulses counted; two in a row is a fault
  always @(posedge clock) begin
    #1;
    if (perr === 1'b1) perr_seen++;
    if (perr === 1'b1 && perr_d === 1'b1) begin
      check_bit("parity pulse width", 1'b0, perr);
    end
    perr_d = perr;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    cyc(4);
    check_word("rise in reset", SSLC_IDLE, rise);
    check_word("fall in reset", SSLC_IDLE, fall);
    check_bit("oof in reset", 1'b1, oof);
    check_bit("ready in reset", 1'b0, wr_ready);
    reset_n = 1'b1;
    wait_rise(SSLC_TRAIN_A, 10);
    check_word("training after reset", SSLC_TRAIN_A, rise);
    @(posedge clock);
    #5;
    check_bit("data clock high", 1'b1, dclk);
    check_word("bus rise half", SSLC_TRAIN_A, {tx_ctl, tx_data});
    @(negedge clock);
    #5;
    check_word("bus fall half", SSLC_TRAIN_A, {tx_ctl, tx_data});
    check_bit("data clock low", 1'b0, dclk);
  endtask
  task automatic t_disabled();
    @(negedge clock);
    bad_dip = 1'b1;
    cyc(30);
    check_num("parity while off", 0, perr_seen);
    check_bit("oof while off", 1'b1, oof);
    check_bit("pattern error off", 1'b0, pat_err);
    wait_rise(SSLC_TRAIN_B, 12);
    check_word("training while off", SSLC_TRAIN_B, rise);
    bad_dip = 1'b0;
  endtask
  task automatic t_sync();
    en = 1'b1;
    brk = 1'b1;
    cyc(3);
    brk = 1'b0;
    wait_oof(1'b0, 100);
    check_num("parity on good frames", 0, perr_seen);
  endtask
  task automatic t_data();
    cyc(20);
    write(32'h1234abcd);
    check_bit("ready while held", 1'b0, wr_ready);
    cyc(10);
    check_word("idle while satisfied", SSLC_IDLE, rise);
    hungry = 1'b1;
    wait_rise('{ctl: 1'b0, data: 16'h1234}, 30);
    check_word("payload rise", '{ctl: 1'b0, data: 16'h1234}, rise);
    check_word("payload fall", '{ctl: 1'b0, data: 16'habcd}, fall);
  endtask
  task automatic t_clear();
    hungry = 1'b0;
    cyc(8);
    write(32'h5a5a0ff0);
    clr_low = 1'b0;
    cyc(2);
    check_bit("ready in clear", 1'b0, wr_ready);
    clr_low = 1'b1;
    hungry = 1'b1;
    wait_rise('{ctl: 1'b0, data: 16'h5a5a}, 20);
    check_word("idle after clear", SSLC_IDLE, rise);
    check_bit("frame kept", 1'b0, oof);
    write(32'h0f0f1e1e);
    wait_rise('{ctl: 1'b0, data: 16'h0f0f}, 30);
    check_word("new write sent", '{ctl: 1'b0, data: 16'h0f0f}, rise);
  endtask
  task automatic t_frame();
    brk = 1'b1;
    cyc(3);
    brk = 1'b0;
    wait_oof(1'b1, 40);
    wait_oof(1'b0, 100);
  endtask
  task automatic t_dip();
    perr_seen = 0;
    bad_dip = 1'b1;
    wait_oof(1'b1, 100);
    cyc(10);
    check_num("parity pulses", 2, perr_seen);
    wait_rise(SSLC_TRAIN_A, 30);
    check_word("training on loss", SSLC_TRAIN_A, rise);
    bad_dip = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #150000;
    fail_count++;
    complete_run();
  end
  initial begin
    t_reset();
    t_disabled();
    t_sync();
    t_data();
    t_clear();
    t_frame();
    t_dip();
    complete_run();
  end
endmodule
`default_nettype wire
